// ### cfw_pkg.sv
// Constants for the write-once configuration word one register bank
package cfw_pkg;

  // ----------------------------------------------------------------
  // Register map (register indices; byte address is four times each)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 24;
  localparam int unsigned IDX_W     = 22;
  localparam logic [IDX_W-1:0] IDX_LOW  = 22'h300000;
  localparam logic [IDX_W-1:0] IDX_HIGH = 22'h300001;
  localparam logic [IDX_W-1:0] IDX_LOCK = 22'h300010;

  // ----------------------------------------------------------------
  // Cell layout: bits 7:0 low byte, bits 15:8 high byte
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned CELL_W    = 16;
  localparam int unsigned BIT_WDT   = 0;
  localparam int unsigned BIT_STACK = 5;
  localparam int unsigned BIT_EXT_INSTR_SET_ENABLE = 6;
  localparam int unsigned BIT_DEBUG = 7;
  localparam int unsigned BIT_CP    = 10;
  localparam logic [CELL_W-1:0] IMPL_MASK  = 16'h04e1;
  localparam logic [CELL_W-1:0] CELL_RESET = 16'h04e1;
  localparam logic [CELL_W-1:0] LOCK_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

endpackage : cfw_pkg

// ### cfw_config_word_one.sv
// Write-once configuration word one bank behind an AXI4-Lite slave
module cfw_config_word_one
  import cfw_pkg::*;
(
  // Clock and power-on reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Power-up image load from flash
  input  wire logic              flash_load_valid,
  input  wire logic [CELL_W-1:0] flash_load_data,
  // Stack events from the core
  input  wire logic              stack_overflow,
  input  wire logic              stack_underflow,
  // Configuration outputs
  output logic                   debug_enable,
  output logic                   ext_instr_set_enable,
  output logic                   indexed_addressing_enable,
  output logic                   stack_fault_reset_enable,
  output logic                   watchdog_enable,
  output logic                   code_protected,
  output logic                   stack_fault_reset
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [CELL_W-1:0] cell_q;
  logic [CELL_W-1:0] lock_q;
  logic              awready_q;
  logic              aw_full_q;
  logic [IDX_W-1:0]  aw_idx_q;
  logic              wready_q;
  logic              w_full_q;
  logic [BYTE_W-1:0] w_byte_q;
  logic              w_lane_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              debug_q, ext_instr_set_enable_q, stack_en_q, wdt_q, cp_q;
  logic              stack_rst_q;
  logic              wr_go, wr_low, wr_high;
  logic [CELL_W-1:0] axi_we;
  logic [CELL_W-1:0] axi_wd;
  logic [IDX_W-1:0]  ar_idx;
  logic [31:0]       rd_word;
  logic              rd_hit;

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  // Address and data are caught independently, so either may come first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      aw_full_q <= 1'b0;
      aw_idx_q  <= '0;
    end
    else if (s_axi_awvalid && awready_q)
    begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b1;
      aw_idx_q  <= s_axi_awaddr[ADDR_W-1:2];
    end
    else if (wr_go)
    begin
      awready_q <= 1'b1;
      aw_full_q <= 1'b0;
    end
  end

  // Registers are one byte wide, so only lane 0 of the word matters
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_q <= 1'b1;
      w_full_q <= 1'b0;
      w_byte_q <= '0;
      w_lane_q <= 1'b0;
    end
    else if (s_axi_wvalid && wready_q)
    begin
      wready_q <= 1'b0;
      w_full_q <= 1'b1;
      w_byte_q <= s_axi_wdata[BYTE_W-1:0];
      w_lane_q <= s_axi_wstrb[0];
    end
    else if (wr_go)
    begin
      wready_q <= 1'b1;
      w_full_q <= 1'b0;
    end
  end

  // The write is carried out once both halves are held and no response is pending
  assign wr_go   = aw_full_q && w_full_q && !bvalid_q;
  assign wr_low  = wr_go && w_lane_q && (aw_idx_q == IDX_LOW);
  assign wr_high = wr_go && w_lane_q && (aw_idx_q == IDX_HIGH);
  assign axi_we  = {{BYTE_W{wr_high}}, {BYTE_W{wr_low}}};
  assign axi_wd  = {w_byte_q, w_byte_q};

  // Write response; writes to locked bits still answer OKAY
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      if ((aw_idx_q == IDX_LOW) || (aw_idx_q == IDX_HIGH))
        bresp_q <= RESP_OKAY;
      else
        bresp_q <= RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
      bvalid_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Write-once cells
  // ----------------------------------------------------------------
  // aresetn is the power-on reset; lesser resets never reach these cells
  // so the programmed image survives them. Flash load beats a bus write.
  genvar gi;
  generate
    for (gi = 0; gi < CELL_W; gi++)
    begin : g_cell
      if (IMPL_MASK[gi])
      begin : g_impl
        always_ff @(posedge aclk)
        begin
          if (!aresetn)
          begin
            cell_q[gi] <= CELL_RESET[gi];
            lock_q[gi] <= LOCK_RESET[gi];
          end
          else if (!lock_q[gi] && flash_load_valid)
          begin
            cell_q[gi] <= flash_load_data[gi];
            lock_q[gi] <= 1'b1;
          end
          else if (!lock_q[gi] && axi_we[gi])
          begin
            cell_q[gi] <= axi_wd[gi];
            lock_q[gi] <= 1'b1;
          end
        end
      end
      else
      begin : g_none
        // Unimplemented bits hold no state and read zero
        assign cell_q[gi] = 1'b0;
        assign lock_q[gi] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign ar_idx = s_axi_araddr[ADDR_W-1:2];

  // Read decode; narrow bytes sit in the low bits, the rest is zero
  always_comb
  begin
    rd_word = WORD_ZERO;
    rd_hit  = 1'b1;
    case (ar_idx)
      IDX_LOW:  rd_word[BYTE_W-1:0] = cell_q[BYTE_W-1:0];
      IDX_HIGH: rd_word[BYTE_W-1:0] = cell_q[CELL_W-1:BYTE_W];
      IDX_LOCK: rd_word[CELL_W-1:0] = lock_q;
      default:  rd_hit = 1'b0;
    endcase
  end

  // One read at a time; address is refused while data is pending
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= WORD_ZERO;
      rresp_q   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  // Registered copies keep every output straight off a flip-flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      debug_q    <= CELL_RESET[BIT_DEBUG];
      ext_instr_set_enable_q    <= CELL_RESET[BIT_EXT_INSTR_SET_ENABLE];
      stack_en_q <= CELL_RESET[BIT_STACK];
      wdt_q      <= CELL_RESET[BIT_WDT];
      cp_q       <= !CELL_RESET[BIT_CP];
    end
    else
    begin
      debug_q    <= cell_q[BIT_DEBUG];
      ext_instr_set_enable_q    <= cell_q[BIT_EXT_INSTR_SET_ENABLE];
      stack_en_q <= cell_q[BIT_STACK];
      wdt_q      <= cell_q[BIT_WDT];
      cp_q       <= !cell_q[BIT_CP];
    end
  end

  // Stack fault reset request, one cycle per event
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stack_rst_q <= 1'b0;
    else
      stack_rst_q <= cell_q[BIT_STACK] && (stack_overflow || stack_underflow);
  end

  assign s_axi_awready             = awready_q;
  assign s_axi_wready              = wready_q;
  assign s_axi_bvalid              = bvalid_q;
  assign s_axi_bresp               = bresp_q;
  assign s_axi_arready             = arready_q;
  assign s_axi_rvalid              = rvalid_q;
  assign s_axi_rdata               = rdata_q;
  assign s_axi_rresp               = rresp_q;
  assign debug_enable              = debug_q;
  assign ext_instr_set_enable      = ext_instr_set_enable_q;
  assign indexed_addressing_enable = ext_instr_set_enable_q;
  assign stack_fault_reset_enable  = stack_en_q;
  assign watchdog_enable           = wdt_q;
  assign code_protected            = cp_q;
  assign stack_fault_reset         = stack_rst_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_low_read_map: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && arready_q && ar_idx == IDX_LOW)
      |=> rvalid_q && rdata_q == {24'h000000, $past(cell_q[BYTE_W-1:0])})
    else $error("low byte read returned wrong value");
  a_high_read_map: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && arready_q && ar_idx == IDX_HIGH)
      |=> rvalid_q && rdata_q[2] == $past(cell_q[BIT_CP]) && rresp_q == RESP_OKAY)
    else $error("high byte read lost code protect bit");
  a_protect_sense: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> code_protected == !$past(cell_q[BIT_CP]))
    else $error("code protect output has wrong sense");
  a_high_top_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && arready_q && ar_idx == IDX_HIGH) ##1 1'b1
      |-> rdata_q[31:3] == 29'h00000000)
    else $error("high byte bits 7 to 3 not zero");
  a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (cell_q & ~IMPL_MASK) == 16'h0000 and
    ((s_axi_arvalid && arready_q && ar_idx == IDX_LOW) |=> rdata_q[4:1] == 4'h0))
    else $error("unimplemented bits not zero");
  a_write_once: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ((cell_q ^ $past(cell_q)) & $past(lock_q)) == 16'h0000)
    else $error("locked configuration bit changed");
  a_first_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_low && !lock_q[BIT_EXT_INSTR_SET_ENABLE] && !flash_load_valid)
      |=> lock_q[BIT_EXT_INSTR_SET_ENABLE] && cell_q[BIT_EXT_INSTR_SET_ENABLE] == $past(w_byte_q[BIT_EXT_INSTR_SET_ENABLE]))
    else $error("first write did not program the bit");
  a_por_ones: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> cell_q == CELL_RESET && lock_q == LOCK_RESET)
    else $error("cells not unprogrammed after power-on reset");
  a_ext_instr_set_enable_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> {ext_instr_set_enable, indexed_addressing_enable} == {2{$past(cell_q[BIT_EXT_INSTR_SET_ENABLE])}})
    else $error("extended instruction enable did not follow");
  a_stack_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    (stack_overflow || stack_underflow)
      |=> stack_fault_reset == $past(cell_q[BIT_STACK]))
    else $error("stack fault reset request wrong");
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> bvalid_q && !aw_full_q && !w_full_q)
    else $error("write response not raised");

endmodule : cfw_config_word_one

// ### cfw_config_word_one_tb_top.sv
// Self-checking bench for the write-once configuration word one bank
module cfw_config_word_one_tb_top
  import cfw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic aclk, aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, flash_load_valid;
  logic [CELL_W-1:0] flash_load_data;
  logic stack_overflow, stack_underflow, stack_fault_reset;
  logic debug_enable, ext_instr_set_enable, indexed_addressing_enable;
  logic stack_fault_reset_enable, watchdog_enable, code_protected;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  localparam logic [ADDR_W-1:0] A_LOW = 24'hc00000;
  localparam logic [ADDR_W-1:0] A_HIGH = 24'hc00004;
  localparam logic [ADDR_W-1:0] A_LOCK = 24'hc00040;
  localparam logic [ADDR_W-1:0] A_NONE = 24'hc00008;

  cfw_config_word_one u_cfw_config_word_one (
    .aclk                      (aclk),
    .aresetn                   (aresetn),
    .s_axi_awaddr              (s_axi_awaddr),
    .s_axi_awprot              (s_axi_awprot),
    .s_axi_awvalid             (s_axi_awvalid),
    .s_axi_awready             (s_axi_awready),
    .s_axi_wdata               (s_axi_wdata),
    .s_axi_wstrb               (s_axi_wstrb),
    .s_axi_wvalid              (s_axi_wvalid),
    .s_axi_wready              (s_axi_wready),
    .s_axi_bresp               (s_axi_bresp),
    .s_axi_bvalid              (s_axi_bvalid),
    .s_axi_bready              (s_axi_bready),
    .s_axi_araddr              (s_axi_araddr),
    .s_axi_arprot              (s_axi_arprot),
    .s_axi_arvalid             (s_axi_arvalid),
    .s_axi_arready             (s_axi_arready),
    .s_axi_rdata               (s_axi_rdata),
    .s_axi_rresp               (s_axi_rresp),
    .s_axi_rvalid              (s_axi_rvalid),
    .s_axi_rready              (s_axi_rready),
    .flash_load_valid          (flash_load_valid),
    .flash_load_data           (flash_load_data),
    .stack_overflow            (stack_overflow),
    .stack_underflow           (stack_underflow),
    .debug_enable              (debug_enable),
    .ext_instr_set_enable      (ext_instr_set_enable),
    .indexed_addressing_enable (indexed_addressing_enable),
    .stack_fault_reset_enable  (stack_fault_reset_enable),
    .watchdog_enable           (watchdog_enable),
    .code_protected            (code_protected),
    .stack_fault_reset         (stack_fault_reset)
  );

  // Free-running clock, 50 ns period
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Compare tasks and closing report
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_word({30'h0, got}, {30'h0, exp});
  endtask
  // Flags: debug, ext, indexed, stack reset enable, watchdog, protected
  task automatic chk_flags(input logic [5:0] exp);
    repeat (2) @(posedge aclk);
    chk_word({26'h0, debug_enable, ext_instr_set_enable, indexed_addressing_enable,
              stack_fault_reset_enable, watchdog_enable, code_protected}, {26'h0, exp});
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Cut a hang short: the whole sequence needs well under 1000 cycles
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite master tasks; each starts one edge after the last one
  // ----------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] exp_r);
    logic aw_ok, w_ok, b_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_ok)
    begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1)
      begin
        b_ok = 1'b1;
        s_axi_bready <= 1'b0;
        chk_resp(s_axi_bresp, exp_r);
      end
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp_d,
                    input logic [1:0] exp_r);
    logic r_ok;
    r_ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_ok)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        r_ok = 1'b1;
        s_axi_rready <= 1'b0;
        chk_word(s_axi_rdata, exp_d);
        chk_resp(s_axi_rresp, exp_r);
      end
    end
  endtask

  // Power-on reset held for 10 cycles
  task automatic por();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic flash(input logic [CELL_W-1:0] d);
    @(posedge aclk);
    flash_load_valid <= 1'b1;
    flash_load_data <= d;
    @(posedge aclk);
    flash_load_valid <= 1'b0;
  endtask
  // Pulse one stack event and count reset pulses seen afterwards
  task automatic stack_ev(input logic under, input logic [31:0] exp_n);
    int n;
    n = 0;
    @(posedge aclk);
    stack_underflow <= under;
    stack_overflow <= ~under;
    repeat (5)
    begin
      @(posedge aclk);
      stack_underflow <= 1'b0;
      stack_overflow <= 1'b0;
      if (stack_fault_reset === 1'b1)
        n++;
    end
    chk_word(32'(n), exp_n);
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, flash_load_valid, stack_overflow, stack_underflow} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awprot, s_axi_arprot, flash_load_data} = '0;
    por();
    rd(A_LOW, 32'h0000_00e1, RESP_OKAY);
    rd(A_HIGH, 32'h0000_0004, RESP_OKAY);
    rd(A_LOCK, 32'h0000_0000, RESP_OKAY);
    chk_flags(6'b111110);
    $display("test reset_values done");
    // First write programs the low byte; a second one is ignored
    wr(A_LOW, 32'hffff_ff5e, 4'hf, RESP_OKAY);
    rd(A_LOW, 32'h0000_0040, RESP_OKAY);
    chk_flags(6'b011000);
    wr(A_LOW, 32'h0000_00ff, 4'hf, RESP_OKAY);
    rd(A_LOW, 32'h0000_0040, RESP_OKAY);
    rd(A_LOCK, 32'h0000_00e1, RESP_OKAY);
    stack_ev(1'b0, 32'h0);
    $display("test low_byte done");
    // Write without the lane 0 strobe leaves the high byte open, then code protect; bit 2 kept low
    wr(A_HIGH, 32'h0000_0000, 4'he, RESP_OKAY);
    rd(A_HIGH, 32'h0000_0004, RESP_OKAY);
    wr(A_HIGH, 32'h0000_00f3, 4'h1, RESP_OKAY);
    rd(A_HIGH, 32'h0000_0000, RESP_OKAY);
    chk_flags(6'b011001);
    wr(A_HIGH, 32'h0000_00f7, 4'h1, RESP_OKAY);
    rd(A_HIGH, 32'h0000_0000, RESP_OKAY);
    flash(16'hf7ff);
    rd(A_LOW, 32'h0000_0040, RESP_OKAY);
    rd(A_LOCK, 32'h0000_04e1, RESP_OKAY);
    $display("test high_byte done");
    // Unmapped and read-only places
    rd(A_NONE, 32'h0000_0000, RESP_SLVERR);
    wr(A_NONE, 32'h0000_0000, 4'hf, RESP_SLVERR);
    wr(A_LOCK, 32'h0000_0000, 4'hf, RESP_SLVERR);
    $display("test errors done");
    // Power-on reset restores the cells; flash image then locks them
    por();
    rd(A_LOW, 32'h0000_00e1, RESP_OKAY);
    rd(A_HIGH, 32'h0000_0004, RESP_OKAY);
    rd(A_LOCK, 32'h0000_0000, RESP_OKAY);
    chk_flags(6'b111110);
    flash(16'hf0bf);
    rd(A_LOW, 32'h0000_00a1, RESP_OKAY);
    rd(A_HIGH, 32'h0000_0000, RESP_OKAY);
    chk_flags(6'b100111);
    stack_ev(1'b1, 32'h1);
    stack_ev(1'b0, 32'h1);
    wr(A_LOW, 32'h0000_0000, 4'h1, RESP_OKAY);
    rd(A_LOW, 32'h0000_00a1, RESP_OKAY);
    $display("test flash_load done");
    end_sim();
  end

endmodule // cfw_config_word_one_tb_top
